/* src/ssc_pkg.sv */
// shared constants and checksum helper for the switch-command spi controller
package ssc_pkg;
  // link timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_MAX_MHZ = 50;
  localparam int SCLK_MIN_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
  // a minimum half period rounds up to whole clock cycles
  localparam int HALF_CYC = (SCLK_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam logic [3:0] DESEL_LAST = 4'(2 * HALF_CYC - 1);
  // frame shape
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS_CRC = 5'h18;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] ALIGN_PATTERN = 8'h25;
  // checksum x^8 + x^2 + x + 1, seed zero
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  // device register map and special frames
  localparam logic [6:0] REG_SOFTWARE_RESET_TRIGGER = 7'h0B;
  localparam logic [7:0] SOFT_RESET_KEY1 = 8'hA3;
  localparam logic [7:0] SOFT_RESET_KEY2 = 8'h05;
  localparam logic [15:0] FLAG_CLEAR_FRAME = 16'h6CA9;

  function automatic logic [7:0] ssc_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : ssc_crc8
endpackage : ssc_pkg

/* src/ssc_spi_host.sv */
// spi controller that drives the octal switch's command interface
// How it works
// RULE_01: mode 0 only, sclk at most 50 MHz
// RULE_02: one frame per select low, 16 clocks
// RULE_03: first bit sent is direction, 1 reads
// RULE_04: seven address bits, then eight data bits
// RULE_05: device latches address, returns read data
// RULE_06: device commits write on sixteenth edge
// RULE_07: device sends 0x25 alignment byte first
// RULE_08: data changes on fall, select held low
// RULE_09: crc mode adds eight clocks, 24 bits
// RULE_10: checksum poly x^8+x^2+x+1, seed zero
// RULE_11: device checks checksum before 24th edge
// RULE_12: controller sends checksum, device returns one
// RULE_13: device crc check resets disabled, per-check flags
// RULE_14: device flags wrong clock count per frame
// RULE_15: short frames never write, long still write
// RULE_16: count and address checks reset enabled
// RULE_17: device flags bad address on ninth edge
// RULE_18: frame 0x6CA9 clears device error flags
// RULE_19: burst keeps select low across commands
// RULE_20: burst clock total must be frame multiple
// RULE_21: writes 0xA3 then 0x05 to 0x0B reset
// RULE_22: all fields shifted msb first
`timescale 1ns/10ps
module ssc_spi_host
  import ssc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [6:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic cmdCrc,
  input wire logic cmdHold,
  output logic cmdReady,
  output logic rspValid,
  output logic [7:0] rspAlign,
  output logic [7:0] rspData,
  output logic [7:0] rspCrc,
  output logic rspCrcOk,
  output logic csN,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);

  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_HOLD, ST_DESEL} ssc_state_e;

  typedef struct packed {
    ssc_state_e st;
    logic [3:0] cnt;
    logic [4:0] bitCnt;
    logic crcOn;
    logic hold;
    logic [23:0] shTx;
    logic [23:0] shRx;
    logic sdoMeta;
    logic sdoSync;
    logic csN;
    logic sclk;
    logic sdi;
    logic cmdReady;
    logic rspValid;
    logic [7:0] rspAlign;
    logic [7:0] rspData;
    logic [7:0] rspCrc;
    logic rspCrcOk;
  } ssc_regs_s;

  ssc_regs_s s_q;
  ssc_regs_s s_d;
  logic accept;
  logic [15:0] payload;
  logic [23:0] rxNext;
  logic [4:0] lenNow;

  assign accept = cmdValid && s_q.cmdReady;
  // read frames carry zero data; the device ignores it
  // flag clear and soft reset are plain writes that the user issues
  assign payload = {cmdRead, cmdAddr, (cmdRead == DIR_READ) ? 8'h00 : cmdData}; // RULE_04 RULE_18 RULE_21
  assign rxNext = {s_q.shRx[22:0], s_q.sdoSync};
  assign lenNow = s_q.crcOn ? FRAME_BITS_CRC : FRAME_BITS; // RULE_02 RULE_09

  always_comb begin
    s_d = s_q;
    s_d.rspValid = 1'b0;
    // sdo is asynchronous to this clock: two stages before use
    s_d.sdoMeta = sdo;
    s_d.sdoSync = s_q.sdoMeta;
    if (accept) begin
      // load msb first, checksum trailing the payload
      s_d.shTx = {payload, cmdCrc ? ssc_crc8(payload) : 8'h00}; // RULE_10 RULE_12 RULE_22
      s_d.sdi = payload[15]; // RULE_03
      s_d.crcOn = cmdCrc;
      s_d.hold = cmdHold;
      s_d.csN = 1'b0;
      s_d.cnt = '0;
      s_d.bitCnt = '0;
      s_d.shRx = '0;
      s_d.st = ST_LOW;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.csN = 1'b1;
        end
        ST_HOLD: begin
          // select stays low so the next command joins the burst
          s_d.csN = 1'b0; // RULE_19
        end
        ST_LOW: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == HALF_LAST) begin
            s_d.cnt = '0;
            s_d.sclk = 1'b1; // RULE_08
            s_d.st = ST_HIGH;
          end
        end
        ST_HIGH: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == HALF_LAST) begin
            s_d.cnt = '0;
            s_d.sclk = 1'b0;
            // synced sdo still shows the bit of the high phase just ending
            s_d.shRx = rxNext;
            s_d.bitCnt = s_q.bitCnt + 5'h01;
            s_d.shTx = {s_q.shTx[22:0], 1'b0};
            s_d.sdi = s_q.shTx[22]; // RULE_08 RULE_22
            if (s_d.bitCnt == lenNow) begin
              s_d.rspValid = 1'b1;
              if (s_q.crcOn) begin
                s_d.rspAlign = rxNext[23:16];
                s_d.rspData = rxNext[15:8];
                s_d.rspCrc = rxNext[7:0];
                s_d.rspCrcOk = (ssc_crc8(rxNext[23:8]) == rxNext[7:0]); // RULE_12
              end else begin
                s_d.rspAlign = rxNext[15:8];
                s_d.rspData = rxNext[7:0];
                s_d.rspCrc = 8'h00;
                s_d.rspCrcOk = 1'b1;
              end
              s_d.sdi = 1'b0;
              s_d.st = s_q.hold ? ST_HOLD : ST_DESEL; // RULE_02 RULE_19
            end else begin
              s_d.st = ST_LOW;
            end
          end
        end
        ST_DESEL: begin
          // hold select after the last fall, then keep it high a while
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == HALF_LAST) begin
            s_d.csN = 1'b1; // RULE_02
          end
          if (s_q.cnt == DESEL_LAST) begin
            s_d.cnt = '0;
            s_d.st = ST_IDLE;
          end
        end
      endcase
    end
    s_d.cmdReady = (s_d.st == ST_IDLE) || (s_d.st == ST_HOLD);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.csN <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign cmdReady = s_q.cmdReady;
  assign rspValid = s_q.rspValid;
  assign rspAlign = s_q.rspAlign;
  assign rspData = s_q.rspData;
  assign rspCrc = s_q.rspCrc;
  assign rspCrcOk = s_q.rspCrcOk;
  assign csN = s_q.csN;
  assign sclk = s_q.sclk;
  assign sdi = s_q.sdi;

  idle_clock_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    s_q.csN |-> !s_q.sclk) else $error("sclk high while select is high");

  select_low_edge_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    $rose(s_q.sclk) |-> !s_q.csN && $past(!s_q.csN)) else $error("sclk rose without select");

  data_stable_high_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    s_q.sclk && $past(s_q.sclk) |-> $stable(s_q.sdi)) else $error("sdi moved while sclk high");

  frame_length_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    $rose(s_q.rspValid) |-> s_q.bitCnt == (s_q.crcOn ? FRAME_BITS_CRC : FRAME_BITS))
    else $error("frame ended at wrong bit count");

  direction_first_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    accept && ce |=> !s_q.csN && s_q.sdi == $past(cmdRead) && !s_q.sclk)
    else $error("first bit is not the direction bit");

  crc_appended_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    accept && ce && cmdCrc |=> s_q.shTx[7:0] == ssc_crc8(s_q.shTx[23:8]))
    else $error("checksum byte does not match payload");

  response_pulse_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    s_q.rspValid && ce |=> !s_q.rspValid) else $error("response valid longer than a cycle");

  select_release_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    $rose(s_q.csN) |-> $past(s_q.st) == ST_DESEL && !s_q.sclk)
    else $error("select released outside frame end");

  burst_select_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_19
    s_q.st == ST_HOLD |-> !s_q.csN) else $error("select rose inside a burst");

  idle_data_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    s_q.csN |-> !s_q.sdi) else $error("sdi not low while deselected");

  select_fall_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    $fell(s_q.csN) |-> !s_q.sclk) else $error("select fell with sclk high");

endmodule : ssc_spi_host

/* tb/ssc_dev_model.sv */
// behavioural switch device on the far side of the spi link
`timescale 1ns/10ps
module ssc_dev_model (
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic crcEn,
  output logic sdo
);
  logic [7:0] mem [128];
  logic [23:0] rx;
  logic [15:0] w;
  logic [7:0] rdat;
  logic [23:0] resp;
  logic armed;
  logic bitQ;
  int cnt;
  int fl;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {armed, rdat, cnt, bitQ} = '0;
  end
  assign fl = crcEn ? 24 : 16;
  assign resp = {8'h25, rdat, crc8({8'h25, rdat})};
  // integrated pull-up: a released line reads high
  assign sdo = csN ? 1'b1 : bitQ;
  always @(negedge csN) begin
    cnt = 0;
    bitQ = resp[23];
  end
  always @(posedge sclk) begin
    if (!csN) begin
      rx = {rx[22:0], sdi};
      cnt++;
      w = crcEn ? rx[23:8] : rx[15:0];
      if (cnt % fl == 8) rdat = mem[rx[6:0]];
      // only whole commands commit, so short frames never write
      if (cnt % fl == 0 && !w[15] && (!crcEn || rx[7:0] == crc8(w))) begin
        if (w[14:8] == 7'h0B) begin
          if (armed && w[7:0] == 8'h05) foreach (mem[i]) mem[i] = 8'h00;
          armed = (w[7:0] == 8'hA3);
        end else begin
          mem[w[14:8]] = w[7:0];
          armed = 1'b0;
        end
      end
    end
  end
  always @(negedge sclk) begin
    if (!csN) bitQ = resp[23 - (cnt % fl)];
  end
endmodule : ssc_dev_model

/* tb/ssc_spi_host_tb_top.sv */
// self-checking bench: controller against the behavioural device
`timescale 1ns/10ps
module ssc_spi_host_tb_top;
  logic clock = 0, rst_n = 0, cmdValid = 0, cmdRead = 0, cmdCrc = 0, cmdHold = 0, crcEn = 0;
  logic ce = 1;
  logic [6:0] cmdAddr = 0;
  logic [7:0] cmdData = 0, rspAlign, rspData, rspCrc;
  logic cmdReady, rspValid, rspCrcOk, csN, sclk, sdi, sdo;
  int nErrors = 0, checksDone = 0, nClk = 0;
  always #4 clock = ~clock;
  always @(negedge csN) nClk = 0;
  always @(posedge sclk) nClk++;
  ssc_spi_host u_ssc_spi_host (.clock(clock), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCrc(cmdCrc), .cmdHold(cmdHold),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspAlign(rspAlign), .rspData(rspData),
    .rspCrc(rspCrc), .rspCrcOk(rspCrcOk), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  ssc_dev_model u_ssc_dev_model (.csN(csN), .sclk(sclk), .sdi(sdi), .crcEn(crcEn), .sdo(sdo));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held until the edge that finds ready high, then wait for the response pulse
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d, input logic h);
    int n;
    @(posedge clock);
    cmdValid <= 1'b1;
    {cmdRead, cmdAddr, cmdData, cmdCrc, cmdHold} <= {r, a, d, crcEn, h};
    n = 0;
    do begin @(negedge clock); n++; end while (cmdReady !== 1'b1 && n < 300);
    if (n >= 300) chk("ready", 8'h01, 8'h00);
    @(posedge clock);
    cmdValid <= 1'b0;
    n = 0;
    do begin @(negedge clock); n++; end while (rspValid !== 1'b1 && n < 300);
    if (n >= 300) chk("response", 8'h01, 8'h00);
  endtask : xfer
  task automatic t_plain();
    xfer(1'b0, 7'h12, 8'h5A, 1'b0);
    chk("clocks", 8'd16, 8'(nClk));
    xfer(1'b1, 7'h12, 8'h00, 1'b0);
    chk("align", 8'h25, rspAlign);
    chk("data", 8'h5A, rspData);
    repeat (6) @(negedge clock);
    chk("select", 8'h01, {7'h0, csN});
    chk("sclk idle", 8'h00, {7'h0, sclk});
  endtask : t_plain
  task automatic t_crc();
    @(posedge clock);
    crcEn <= 1'b1;
    xfer(1'b0, 7'h13, 8'hC3, 1'b0);
    chk("clocks", 8'd24, 8'(nClk));
    xfer(1'b1, 7'h13, 8'h00, 1'b0);
    chk("data", 8'hC3, rspData);
    chk("crc", u_ssc_dev_model.crc8({8'h25, 8'hC3}), rspCrc);
    chk("crc ok", 8'h01, {7'h0, rspCrcOk});
    @(posedge clock);
    crcEn <= 1'b0;
  endtask : t_crc
  task automatic t_burst();
    xfer(1'b0, 7'h14, 8'h66, 1'b1);
    xfer(1'b1, 7'h14, 8'h00, 1'b0);
    chk("clocks", 8'd32, 8'(nClk));
    chk("data", 8'h66, rspData);
  endtask : t_burst
  // clock enable dropped mid-frame: the frame must resume intact
  task automatic t_freeze();
    fork
      xfer(1'b1, 7'h14, 8'h00, 1'b0);
      begin
        repeat (20) @(posedge clock);
        ce <= 1'b0;
        repeat (10) @(posedge clock);
        ce <= 1'b1;
      end
    join
    chk("frozen data", 8'h66, rspData);
  endtask : t_freeze
  task automatic t_reset();
    xfer(1'b0, 7'h0B, 8'hA3, 1'b0);
    xfer(1'b0, 7'h0B, 8'h05, 1'b0);
    xfer(1'b1, 7'h12, 8'h00, 1'b0);
    chk("data", 8'h00, rspData);
  endtask : t_reset
  task automatic conclude();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_plain();
    t_crc();
    t_burst();
    t_freeze();
    t_reset();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    conclude();
  end
endmodule : ssc_spi_host_tb_top
